/* File: rtl/serial_port.sv */
// byte-wide synchronous serial port, master or slave
`timescale 1ns/100ps
module serial_port
  import serial_port_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input cpu_req_s CPU_REQ,
  output logic [7:0] CR_Q,
  output logic [7:0] CSR_Q,
  output logic [7:0] DR_Q,
  output logic IRQ,
  output logic WAKE_HALT,
  input wire logic IRQ_MASK,
  input wire logic HALT,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SS_N
);

  // half period for a rate setting {bit2,bit1,bit0}
  function automatic logic [6:0] half_count(input logic [2:0] sel);
    logic [6:0] h;
    h = HALF_DIV4;
    case (sel)
      3'b100: h = HALF_DIV4;
      3'b000: h = HALF_DIV8;
      3'b001: h = HALF_DIV16;
      3'b110: h = HALF_DIV32;
      3'b010: h = HALF_DIV64;
      3'b011: h = HALF_DIV128;
      3'b101: h = HALF_DIV4;
      default: h = HALF_DIV128;
    endcase
    return h;
  endfunction

  // synchronised pin levels: {ss, miso, mosi, sck}
  logic [3:0] pin_lvl;
  pin_sync #(.WIDTH(4)) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .PIN({SS_N, MISO_I, MOSI_I, SCK_I}),
    .LEVEL(pin_lvl)
  );
  wire sck_s = pin_lvl[0];
  wire mosi_s = pin_lvl[1];
  wire miso_s = pin_lvl[2];
  wire ss_pin_s = pin_lvl[3];

  // software registers
  logic [7:0] cr_reg;
  logic [7:0] cr_next;
  logic out_dis_reg;
  logic soft_sel_reg;
  logic sel_lvl_reg;
  logic [7:0] rx_buf_reg;
  // flags and their clearing-sequence arms
  logic done_reg;
  logic done_arm_reg;
  logic done_rd_reg;
  logic write_collision_flag_reg;
  logic write_collision_flag_arm_reg;
  logic ovr_reg;
  logic mode_fault_flag_reg;
  logic mode_fault_flag_arm_reg;
  // transfer engine
  master_state_e state_reg;
  master_state_e state_next;
  logic [6:0] div_reg;
  logic [4:0] edge_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic sck_reg;
  logic sck_prev_reg;
  // registered outputs
  logic [7:0] csr_q_reg;
  logic irq_reg;
  logic wake_reg;
  logic sck_oe_reg;
  logic mosi_oe_reg;
  logic miso_oe_reg;

  // control fields
  wire irq_en = cr_reg[CR_IRQ_EN_POS];
  wire port_en = cr_reg[CR_PORT_EN_POS];
  wire master_sel = cr_reg[CR_MASTER_POS];
  wire cpol = cr_reg[CR_CPOL_POS];
  wire cpha = cr_reg[CR_CPHA_POS];
  wire [2:0] rate_select = {cr_reg[CR_RATE2_POS], cr_reg[CR_RATE1_POS], cr_reg[CR_RATE0_POS]};
  wire [6:0] half_cnt = half_count(rate_select);

  // internal select: bit when soft managed, else pin
  wire sel_n = soft_sel_reg ? sel_lvl_reg : ss_pin_s;
  wire master_on = port_en & master_sel;
  wire slave_on = port_en & ~master_sel;

  // cpu accesses freeze while halted
  wire run = ~HALT;
  wire cr_wr = CPU_REQ.cr_wr & run;
  wire csr_rd = CPU_REQ.csr_rd & run;
  wire csr_wr = CPU_REQ.csr_wr & run;
  wire dr_rd = CPU_REQ.dr_rd & run;
  wire dr_wr = CPU_REQ.dr_wr & run;
  wire csr_acc = csr_rd | csr_wr;

  // master edge: divider reaches half period while running
  wire m_running = (state_reg == ST_RUN) & run;
  wire m_tick = m_running & (div_reg == half_cnt - 7'h01);
  // slave edge: synced clock changes while selected
  wire s_edge = slave_on & ~sel_n & (sck_s != sck_prev_reg);
  wire edge_ev = master_on ? m_tick : s_edge;
  // leading edge leaves the idle level
  wire edge_lead = master_on ? ~edge_reg[0] : (sck_s != cpol);
  wire capture = edge_lead ^ cpha;
  wire first_shift = cpha & (edge_reg == 5'h00);
  wire rx_bit = master_on ? miso_s : mosi_s;
  wire byte_end = edge_ev & (edge_reg == EDGES_PER_BYTE - 5'h01);
  wire [7:0] rx_byte = capture ? {rx_reg[6:0], rx_bit} : rx_reg;

  // busy: master running, or slave mid-byte / selected in phase-0
  wire s_busy = slave_on & ~sel_n & (~cpha | (edge_reg != 5'h00));
  wire busy = (state_reg != ST_IDLE) | s_busy;

  // data write handling
  wire dr_inhibit = done_reg & ~done_rd_reg;
  wire dr_collide = dr_wr & ~dr_inhibit & busy;
  wire dr_load = dr_wr & ~dr_inhibit & ~busy;
  wire m_start = dr_load & master_on;

  // flag events
  wire mode_fault_flag_ev = master_sel & ~sel_n;
  wire ovr_ev = byte_end & done_reg;
  wire done_clr = done_arm_reg & (dr_rd | (dr_wr & ~master_sel));
  wire write_collision_flag_clr = write_collision_flag_arm_reg & (dr_rd | dr_wr);
  wire mode_fault_flag_clr = mode_fault_flag_arm_reg & cr_wr;

  // control write, enable and master refused during a fault
  always_comb begin
    cr_next = cr_reg;
    if (cr_wr) begin
      cr_next = CPU_REQ.wdata;
      if (mode_fault_flag_reg & ~mode_fault_flag_arm_reg) begin
        cr_next[CR_PORT_EN_POS] = 1'b0;
        cr_next[CR_MASTER_POS] = 1'b0;
      end
    end
    if (mode_fault_flag_ev) begin
      cr_next[CR_PORT_EN_POS] = 1'b0;
      cr_next[CR_MASTER_POS] = 1'b0;
    end
  end

  // control and status configuration registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cr_reg <= CR_RESET;
      out_dis_reg <= CSR_RESET[CSR_OUT_DIS_POS];
      soft_sel_reg <= CSR_RESET[CSR_SOFT_SEL_POS];
      sel_lvl_reg <= CSR_RESET[CSR_SEL_LVL_POS];
    end else begin
      cr_reg <= cr_next;
      if (csr_wr) begin
        out_dis_reg <= CPU_REQ.wdata[CSR_OUT_DIS_POS];
        soft_sel_reg <= CPU_REQ.wdata[CSR_SOFT_SEL_POS];
        sel_lvl_reg <= CPU_REQ.wdata[CSR_SEL_LVL_POS];
      end
    end
  end

  // transfer-done flag and its arms; a new byte end wins
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      done_reg <= 1'b0;
      done_arm_reg <= 1'b0;
      done_rd_reg <= 1'b0;
    end else if (byte_end) begin
      done_reg <= 1'b1;
      done_arm_reg <= done_reg & (done_arm_reg | csr_acc) & ~done_clr;
      done_rd_reg <= done_reg & (done_rd_reg | csr_rd) & ~done_clr;
    end else if (done_clr) begin
      done_reg <= 1'b0;
      done_arm_reg <= 1'b0;
      done_rd_reg <= 1'b0;
    end else if (done_reg) begin
      done_arm_reg <= done_arm_reg | csr_acc;
      done_rd_reg <= done_rd_reg | csr_rd;
    end
  end

  // overrun: set wins over the status-read clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ovr_reg <= 1'b0;
    end else if (ovr_ev) begin
      ovr_reg <= 1'b1;
    end else if (csr_rd) begin
      ovr_reg <= 1'b0;
    end
  end

  // write collision flag, status only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      write_collision_flag_reg <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
    end else if (dr_collide) begin
      write_collision_flag_reg <= 1'b1;
      write_collision_flag_arm_reg <= 1'b0;
    end else if (write_collision_flag_clr) begin
      write_collision_flag_reg <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
    end else if (write_collision_flag_reg & csr_rd) begin
      write_collision_flag_arm_reg <= 1'b1;
    end
  end

  // mode fault flag
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_fault_flag_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (mode_fault_flag_ev) begin
      mode_fault_flag_reg <= 1'b1;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (mode_fault_flag_clr) begin
      mode_fault_flag_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (mode_fault_flag_reg & csr_rd) begin
      mode_fault_flag_arm_reg <= 1'b1;
    end
  end

  // receive buffer keeps first byte after the last clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_buf_reg <= DATA_RESET;
    end else if (byte_end & ~done_reg) begin
      rx_buf_reg <= rx_byte;
    end
  end

  // master state sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (m_start) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!master_on) begin
          state_next = ST_IDLE;
        end else if (byte_end) begin
          state_next = ST_LAST;
        end
      end
      ST_LAST: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // master divider and state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      div_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      if (!m_running || m_tick) begin
        div_reg <= 7'h00;
      end else begin
        div_reg <= div_reg + 7'h01;
      end
    end
  end

  // edge counter, cleared when idle or deselected
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      edge_reg <= 5'h00;
    end else if (byte_end || !port_en || (slave_on && sel_n) || m_start) begin
      edge_reg <= 5'h00;
    end else if (edge_ev) begin
      edge_reg <= edge_reg + 5'h01;
    end
  end

  // shift registers: msb first out, capture into rx
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_reg <= DATA_RESET;
      rx_reg <= DATA_RESET;
    end else if (dr_load) begin
      tx_reg <= CPU_REQ.wdata;
    end else if (edge_ev) begin
      rx_reg <= rx_byte;
      if (!capture && !first_shift) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // master clock level, idles at polarity
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sck_reg <= 1'b0;
      sck_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s; // always tracks, so enabling gives no false edge
      if (state_reg != ST_RUN) begin
        sck_reg <= cpol;
      end else if (m_tick) begin
        sck_reg <= ~sck_reg;
      end
    end
  end

  // status image, interrupt, wake and pin enables
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      csr_q_reg <= CSR_RESET;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      csr_q_reg <= {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg, 1'b0,
                    out_dis_reg, soft_sel_reg, sel_lvl_reg};
      irq_reg <= irq_en & ~IRQ_MASK & (done_reg | ovr_reg | mode_fault_flag_reg);
      wake_reg <= HALT & irq_en & done_reg;
      sck_oe_reg <= master_on;
      mosi_oe_reg <= master_on & ~out_dis_reg;
      miso_oe_reg <= slave_on & ~sel_n & ~out_dis_reg;
    end
  end

  // outputs, all from flip-flops
  assign CR_Q = cr_reg;
  assign CSR_Q = csr_q_reg;
  assign DR_Q = rx_buf_reg;
  assign IRQ = irq_reg;
  assign WAKE_HALT = wake_reg;
  assign SCK_O = sck_reg;
  assign SCK_OE = sck_oe_reg;
  assign MOSI_O = tx_reg[7];
  assign MOSI_OE = mosi_oe_reg;
  assign MISO_O = tx_reg[7];
  assign MISO_OE = miso_oe_reg;

endmodule

/* File: rtl/serial_port_pkg.sv */
// shared constants and types of the byte-wide serial port
package serial_port_pkg;

  // control register field positions
  localparam int CR_IRQ_EN_POS = 7;
  localparam int CR_PORT_EN_POS = 6;
  localparam int CR_RATE2_POS = 5;
  localparam int CR_MASTER_POS = 4;
  localparam int CR_CPOL_POS = 3;
  localparam int CR_CPHA_POS = 2;
  localparam int CR_RATE1_POS = 1;
  localparam int CR_RATE0_POS = 0;

  // control/status register field positions
  localparam int CSR_DONE_POS = 7;
  localparam int CSR_WRITE_COLLISION_FLAG_POS = 6;
  localparam int CSR_OVR_POS = 5;
  localparam int CSR_MODE_FAULT_FLAG_POS = 4;
  localparam int CSR_OUT_DIS_POS = 2;
  localparam int CSR_SOFT_SEL_POS = 1;
  localparam int CSR_SEL_LVL_POS = 0;

  // software-writable bits of the control/status register
  localparam logic [7:0] CSR_WR_MASK = 8'h07;

  // values after reset
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // half serial-clock period in cpu cycles, per rate setting
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // clock edges in one byte (two per bit)
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  // master engine states, one bit changes per step except LAST back to IDLE
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_LAST = 2'b11
  } master_state_e;

  // one cpu access, strobes are one-cycle pulses
  typedef struct packed {
    logic cr_wr;
    logic csr_rd;
    logic csr_wr;
    logic dr_rd;
    logic dr_wr;
    logic [7:0] wdata;
  } cpu_req_s;

endpackage

/* File: rtl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync
  import serial_port_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [WIDTH-1:0] PIN,
  output logic [WIDTH-1:0] LEVEL
);

  // first stage, read only by the second
  logic [WIDTH-1:0] meta_reg;
  // second and third stages
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  // filtered level
  logic [WIDTH-1:0] level_reg;
  // bits where stages two and three agree
  wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
  wire [WIDTH-1:0] level_next = (agree & s3_reg) | (~agree & level_reg);

  // shift chain and filtered output
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      meta_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      level_reg <= '1;
    end else begin
      meta_reg <= PIN;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign LEVEL = level_reg;

endmodule

/* File: tb/serial_port_chk.sv */
// port-level assertions for the serial port
`timescale 1ns/100ps
module serial_port_chk
  import serial_port_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input cpu_req_s CPU_REQ,
  input logic [7:0] CR_Q,
  input logic [7:0] CSR_Q,
  input logic IRQ,
  input logic WAKE_HALT,
  input wire logic IRQ_MASK,
  input wire logic HALT,
  input logic SCK_O,
  input logic SCK_OE,
  input logic MOSI_OE,
  input logic MISO_OE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  logic fault_arm_reg; // status read seen while fault shown
  logic done_arm_reg; // status access seen while done shown

  // arm the clearing sequences, drop when flag is gone
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fault_arm_reg <= 1'b0;
      done_arm_reg <= 1'b0;
    end else begin
      fault_arm_reg <= CSR_Q[CSR_MODE_FAULT_FLAG_POS] & (fault_arm_reg | (CPU_REQ.csr_rd & ~HALT));
      done_arm_reg <= CSR_Q[CSR_DONE_POS] &
        (done_arm_reg | ((CPU_REQ.csr_rd | CPU_REQ.csr_wr) & ~HALT));
    end
  end

  // control write in the two clearing states
  sequence s_fault_armed;
    fault_arm_reg && CPU_REQ.cr_wr && !HALT;
  endsequence
  sequence s_fault_raw;
    !fault_arm_reg && CSR_Q[CSR_MODE_FAULT_FLAG_POS] && CPU_REQ.cr_wr && !HALT;
  endsequence

  a_irq_level: assert property (IRQ == ($past(CR_Q[7]) && !$past(IRQ_MASK) &&
    (CSR_Q[7] || CSR_Q[5] || CSR_Q[4]))) else $error("irq level wrong");
  a_wake_halt: assert property (WAKE_HALT == ($past(HALT) && $past(CR_Q[7]) &&
    CSR_Q[7])) else $error("halt wake wrong");
  a_fault_drops: assert property ($rose(CSR_Q[4]) |-> !CR_Q[6] && !CR_Q[4])
    else $error("fault kept mode bits");
  a_fault_refuse: assert property (s_fault_raw |=> !CR_Q[6] && !CR_Q[4])
    else $error("fault allowed enable");
  a_fault_clear: assert property (s_fault_armed |-> ##2 !CSR_Q[4])
    else $error("fault not cleared");
  a_ovr_clear: assert property (CPU_REQ.csr_rd && !HALT && CSR_Q[5] |-> ##2 !CSR_Q[5])
    else $error("overrun not cleared");
  a_done_clear: assert property (done_arm_reg && CPU_REQ.dr_rd && !HALT |-> ##2 !CSR_Q[7])
    else $error("done not cleared");
  a_sck_half: assert property ({CR_Q[5], CR_Q[1:0]} == 3'b001 && SCK_OE && $changed(SCK_O)
    |=> $stable(SCK_O) [*7]) else $error("clock half period wrong");
  a_oe_apart: assert property (MOSI_OE |-> SCK_OE && !MISO_OE)
    else $error("output enables clash");
endmodule

bind serial_port serial_port_chk u_chk (.CLK(CLK), .NRST(NRST), .CPU_REQ(CPU_REQ),
  .CR_Q(CR_Q), .CSR_Q(CSR_Q), .IRQ(IRQ), .WAKE_HALT(WAKE_HALT), .IRQ_MASK(IRQ_MASK),
  .HALT(HALT), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE));

/* File: tb/serial_slave_model.sv */
// external slave on the serial lines, phase 0 polarity 0
`timescale 1ns/100ps
module serial_slave_model (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh_reg; // outgoing byte image
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh_reg = 8'h00;
  end
  // select: load byte, msb out before first edge
  always @(negedge sel_n) begin
    sh_reg = tx;
    miso = tx[7];
  end
  // leading edge captures master data
  always @(posedge sck) begin
    if (!sel_n) begin
      rx = {rx[6:0], mosi};
    end
  end
  // trailing edge puts out next bit
  always @(negedge sck) begin
    if (!sel_n) begin
      sh_reg = {sh_reg[6:0], 1'b0};
      miso = sh_reg[7];
    end
  end
  // released line shows no stale level
  always @(posedge sel_n) begin
    miso = ~miso;
  end
endmodule

/* File: tb/serial_port_tb.sv */
// self-checking bench for the serial port in master and slave mode
`timescale 1ns/100ps
module serial_port_tb;
  import serial_port_pkg::*;
  // strobe codes: cr_wr csr_rd csr_wr dr_rd dr_wr
  localparam logic [4:0] CRW = 5'h10;
  localparam logic [4:0] CSRR = 5'h08;
  localparam logic [4:0] CSRW = 5'h04;
  localparam logic [4:0] DRR = 5'h02;
  localparam logic [4:0] DRW = 5'h01;
  logic clk, nrst, irq_mask, halt, ss_n, sel_n;
  cpu_req_s req;
  logic [7:0] s_tx, s_rx, cr_q, csr_q, dr_q;
  logic irq, wake, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, s_miso;
  logic sck_w, mosi_w, miso_w; // resolved pin levels
  logic m_sck, m_mosi; // bench master clock and data
  logic [7:0] mq; // byte seen by the bench master
  int n_mismatch, num_checks;

  // pins: the bench master drives clock and data unless the port does
  assign sck_w = sck_oe ? sck_o : m_sck;
  assign mosi_w = mosi_oe ? mosi_o : m_mosi;
  assign miso_w = miso_oe ? miso_o : s_miso;

  serial_port u_dut (.CLK(clk), .NRST(nrst), .CPU_REQ(req), .CR_Q(cr_q), .CSR_Q(csr_q),
    .DR_Q(dr_q), .IRQ(irq), .WAKE_HALT(wake), .IRQ_MASK(irq_mask), .HALT(halt),
    .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N(ss_n));
  serial_slave_model u_peer (.sck(sck_w), .sel_n(sel_n), .mosi(mosi_w), .tx(s_tx),
    .miso(s_miso), .rx(s_rx));

  // 100 ns clock
  always #50 clk = ~clk;

  // one cpu strobe, then let the status image settle
  task acc(input logic [4:0] s, input logic [7:0] d);
    @(negedge clk);
    req = cpu_req_s'({s, d});
    @(negedge clk);
    req = '0;
    repeat (2) @(negedge clk);
  endtask
  // compare seen against expected
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for a status bit
  task wait_flag(input int b);
    int i;
    for (i = 0; i < 600 && csr_q[b] !== 1'b1; i++) @(negedge clk);
    if (i == 600) begin
      n_mismatch++;
      $display("Error at %0t ns: flag %0d never set", $time, b);
    end
    repeat (2) @(negedge clk);
  endtask
  // reselect the peer with a new byte
  task peer_load(input logic [7:0] d);
    @(negedge clk);
    sel_n = 1'b1;
    s_tx = d;
    @(negedge clk);
    sel_n = 1'b0;
  endtask
  // bench as master: one byte, eight clocks of 16 cpu cycles each
  task m_byte(input logic ph, input logic [7:0] d, output logic [7:0] q);
    int k;
    q = 8'h00;
    for (k = 7; k >= 0; k--) begin
      if (!ph) begin
        m_mosi = d[k];
      end
      repeat (8) @(negedge clk);
      m_sck = ~m_sck;
      if (ph) begin
        m_mosi = d[k];
      end else begin
        q[k] = miso_w;
      end
      repeat (8) @(negedge clk);
      m_sck = ~m_sck;
      if (ph) begin
        q[k] = miso_w;
      end
    end
    repeat (8) @(negedge clk);
  endtask

  // transfer, collision, ignored write, clearing
  task t_master;
    acc(CRW, 8'h01);
    acc(CSRW, 8'h00);
    acc(CRW, 8'h51);
    chk(cr_q, 8'h51);
    peer_load(8'hA5);
    acc(DRW, 8'h3C);
    acc(DRW, 8'hFF);
    wait_flag(7);
    chk(s_rx, 8'h3C);
    chk(dr_q, 8'hA5);
    chk(csr_q & 8'hE0, 8'hC0);
    chk({7'h00, irq}, 8'h00);
    acc(DRW, 8'h11);
    acc(CSRR, 8'h00);
    acc(DRR, 8'h00);
    chk(csr_q & 8'hC0, 8'h00);
    repeat (150) @(negedge clk);
    chk(csr_q & 8'h80, 8'h00);
    chk(s_rx, 8'h3C);
    $display("test master transfer finished");
  endtask

  // byte completes while done still set
  task t_overrun;
    acc(CRW, 8'hD1);
    peer_load(8'h5A);
    acc(DRW, 8'hB7);
    wait_flag(7);
    chk({7'h00, irq}, 8'h01);
    acc(CSRR, 8'h00);
    peer_load(8'hC3);
    acc(DRW, 8'h96);
    wait_flag(5);
    chk(dr_q, 8'h5A);
    chk(s_rx, 8'h96);
    acc(CSRR, 8'h00);
    chk(csr_q & 8'hA0, 8'h80);
    @(negedge clk);
    irq_mask = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    irq_mask = 1'b0;
    acc(DRR, 8'h00);
    chk(csr_q & 8'h80, 8'h00);
    $display("test overrun finished");
  endtask

  // select pulled low in master mode
  task t_fault;
    @(negedge clk);
    ss_n = 1'b0;
    wait_flag(4);
    chk(cr_q & 8'h50, 8'h00);
    chk({7'h00, irq}, 8'h01);
    acc(CRW, 8'h51);
    chk(cr_q, 8'h01);
    ss_n = 1'b1;
    repeat (6) @(negedge clk);
    acc(CSRR, 8'h00);
    acc(CRW, 8'h51);
    chk(cr_q, 8'h51);
    chk(csr_q & 8'h10, 8'h00);
    $display("test mode fault finished");
  endtask

  // slave, phase 0, select pin raised between bytes
  task t_slave;
    acc(CRW, 8'h00);
    acc(CSRW, 8'h00);
    acc(CRW, 8'h40);
    acc(DRW, 8'h6E);
    ss_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({7'h00, miso_oe}, 8'h01);
    m_byte(1'b0, 8'h9D, mq);
    chk(mq, 8'h6E);
    chk(csr_q & 8'hE0, 8'h80);
    chk(dr_q, 8'h9D);
    ss_n = 1'b1;
    repeat (6) @(negedge clk);
    ss_n = 1'b0;
    fork
      m_byte(1'b0, 8'h42, mq);
      begin
        repeat (40) @(negedge clk);
        acc(CSRR, 8'h00);
        acc(DRR, 8'h00);
      end
    join
    chk(csr_q & 8'hE0, 8'h80);
    chk(dr_q, 8'h42);
    ss_n = 1'b1;
    repeat (6) @(negedge clk);
    acc(CSRR, 8'h00);
    acc(DRW, 8'h81);
    chk(csr_q & 8'h80, 8'h00);
    ss_n = 1'b0;
    repeat (6) @(negedge clk);
    acc(DRW, 8'h55);
    chk(csr_q & 8'h40, 8'h40);
    m_byte(1'b0, 8'h24, mq);
    chk(mq, 8'h81);
    ss_n = 1'b1;
    acc(CSRR, 8'h00);
    acc(DRR, 8'h00);
    chk(csr_q & 8'hC0, 8'h00);
    $display("test slave phase 0 finished");
  endtask

  // slave, phase 1, polarity 1, select held low by software
  task t_soft;
    acc(CRW, 8'h00);
    m_sck = 1'b1;
    acc(CSRW, 8'h02);
    acc(CRW, 8'h4C);
    acc(DRW, 8'hC6);
    m_byte(1'b1, 8'h3B, mq);
    chk(mq, 8'hC6);
    chk(dr_q, 8'h3B);
    $display("test slave soft select finished");
  endtask

  // two bytes received while halted
  task t_halt;
    acc(CRW, 8'hCC);
    acc(CSRR, 8'h00);
    acc(DRR, 8'h00);
    chk({7'h00, irq}, 8'h00);
    halt = 1'b1;
    acc(CRW, 8'h00);
    chk(cr_q, 8'hCC);
    m_byte(1'b1, 8'h71, mq);
    chk({7'h00, wake}, 8'h01);
    m_byte(1'b1, 8'h18, mq);
    halt = 1'b0;
    chk(dr_q, 8'h71);
    chk(csr_q & 8'hA0, 8'hA0);
    chk({7'h00, irq}, 8'h01);
    acc(CSRR, 8'h00);
    chk(csr_q & 8'h20, 8'h00);
    chk({7'h00, wake}, 8'h00);
    $display("test halt wake finished");
  endtask

  // counts, verdict, end of run
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    irq_mask = 1'b0;
    halt = 1'b0;
    ss_n = 1'b1;
    sel_n = 1'b1;
    s_tx = 8'h00;
    m_sck = 1'b0;
    m_mosi = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    chk(cr_q, CR_RESET);
    t_master;
    t_overrun;
    t_fault;
    t_slave;
    t_soft;
    t_halt;
    print_verdict;
  end

  // watchdog well past the expected run
  initial begin
    #(100 * 5000);
    n_mismatch++;
    $display("Error at %0t ns: watchdog expired", $time);
    print_verdict;
  end
endmodule
